// File: hw/slc_channel.sv
// One channel of the serial link transceiver: encode, serialize, frame, decode, buffer, self-test.
// Overview of operation
// (RQ1) Each character cycle the transmitter takes either an 8-bit data character or a ready 10-bit character.
// (RQ2) With encoding on, the captured data character is 8B/10B encoded before serialization.
// (RQ3) Bits leave at ten or twenty times the channel reference rate, as selected.
// (RQ4) The receiver takes its serial stream from whichever of two inputs is selected.
// (RQ5) Received bits are deserialized, framed into characters, decoded and checked for errors.
// (RQ6) Received characters go into an elasticity buffer from which the host side reads them.
// (RQ7) Encoder and decoder can each be bypassed so raw 10-bit characters pass unchanged.
// (RQ8) Transmit characters are taken on the local reference timing; receive output follows either timing.
// (RQ9) The channel has its own self-test pattern generator and checker.
// (RQ10) The channel runs from its own reference clock, independently of other channels.
// (RQ11) Framing aligns on the comma alone or on a full K28.5, in single or multi-character mode.
// (RQ12) Invalid codes and disparity faults are flagged to the host with the character.
// (RQ13) A framing pattern seen off the current boundary moves the boundary to start a new character; multi-character mode needs two at the same offset.
`timescale 1ns/1ns
`default_nettype none
module slc_channel
    import slc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enc_en,
    input wire logic dec_en,
    input wire slc_pkg::slc_rate_t rate_sel,
    input wire logic [slc_pkg::CHAR_W-1:0] tx_data,
    input wire logic tx_k,
    output logic tx_ready,
    output logic ser_out,
    input wire logic rx_in_sel,
    input wire logic rx_in0,
    input wire logic rx_in1,
    input wire logic rx_bit_vld,
    input wire logic frame_en,
    input wire logic frame_full,
    input wire logic frame_multi,
    input wire slc_pkg::slc_outclk_t rx_out_sel,
    input wire logic bist_en,
    output logic [slc_pkg::CHAR_W-1:0] rx_data,
    output logic rx_k,
    output logic rx_err,
    output logic rx_vld,
    output logic bist_err
);
    import slc_pkg::*;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = s[0] ? ((s >> 1) ^ LFSR_POLY) : (s >> 1);
    endfunction

    // Returns {running disparity after, code}. Only K28.y is supported as a control code.
    function automatic logic [10:0] enc(input logic [7:0] d, input logic k, input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic r1;
        logic a7;
        s6 = k ? K28_6B_N : T6[d[4:0]];
        if (rd && ($countones(s6) != ONES6_BAL || s6 == D7_6B_N)) begin
            s6 = ~s6;
        end
        r1 = rd ^ ($countones(s6) != ONES6_BAL);
        a7 = (d[7:5] == Y_ALT) && (k || (!r1 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
            || (r1 && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)));
        s4 = a7 ? ALT7_N : T4[d[7:5]];
        if (r1 && ($countones(s4) != ONES4_BAL || d[7:5] == Y_THREE)) begin
            s4 = ~s4;
        end
        // Balanced control tails flip with disparity so the comma stays unique.
        if (k && !r1 && $countones(s4) == ONES4_BAL && d[7:5] != Y_THREE) begin
            s4 = ~s4;
        end
        enc = {r1 ^ ($countones(s4) != ONES4_BAL), s6, s4};
    endfunction

    // Returns {running disparity after, error, k, data}.
    function automatic logic [10:0] dec(input logic [9:0] c, input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic [4:0] x;
        logic [2:0] y;
        logic f6;
        logic f4;
        logic k;
        logic bad;
        logic r1;
        int n6;
        int n4;
        c6 = c[9:4];
        c4 = c[3:0];
        x = '0;
        y = '0;
        f6 = 1'b0;
        f4 = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (c6 == T6[i] || (c6 == ~T6[i] && ($countones(T6[i]) != ONES6_BAL || i == 7))) begin
                x = 5'(i);
                f6 = 1'b1;
            end
        end
        k = (c6 == K28_6B_N || c6 == K28_6B_P);
        if (k) begin
            x = K28_X;
            f6 = 1'b1;
        end
        n6 = $countones(c6);
        n4 = $countones(c4);
        bad = (n6 == ONES6_HI && rd) || (n6 == ONES6_LO && !rd);
        r1 = (n6 == ONES6_BAL) ? rd : (n6 == ONES6_HI);
        if (k && !r1 && n4 == ONES4_BAL && c4 != DX3_N && c4 != DX3_P) begin
            c4 = ~c4;
        end
        for (int j = 0; j < 8; j++) begin
            if (c4 == T4[j] || (c4 == ~T4[j] && ($countones(T4[j]) != ONES4_BAL || j == 3))) begin
                y = 3'(j);
                f4 = 1'b1;
            end
        end
        if (c4 == ALT7_N || c4 == ALT7_P) begin
            y = Y_ALT;
            f4 = 1'b1;
        end
        bad = bad || (n4 == ONES4_HI && r1) || (n4 == ONES4_LO && !r1);
        dec = {(n4 == ONES4_BAL) ? r1 : (n4 == ONES4_HI), !f6 || !f4 || bad, k, y, x};
    endfunction

    // Transmit side. sys_clk stands in for the reference clock: every register here runs on it. [RQ10]
    logic [3:0] tx_cnt_q, tx_cnt_d;
    logic tx_div_q, tx_div_d;
    logic [9:0] tx_sh_q, tx_sh_d;
    logic tx_rd_q, tx_rd_d;
    logic [7:0] gen_q, gen_d;
    logic [10:0] enc_res;
    logic [9:0] tx_code;
    logic bit_tick;

    always_comb begin
        bit_tick = (rate_sel == SLC_RATE_X20) || tx_div_q; // [RQ3]
        tx_ready = bit_tick && (tx_cnt_q == BIT_LAST); // [RQ8]
        enc_res = enc(bist_en ? gen_q : tx_data[7:0], tx_k && !bist_en, tx_rd_q);
        if (bist_en || enc_en) begin
            tx_code = enc_res[9:0]; // [RQ2] [RQ9]
        end else begin
            tx_code = tx_data; // [RQ7]
        end
        tx_div_d = (rate_sel == SLC_RATE_X20) ? 1'b0 : !tx_div_q;
        tx_cnt_d = tx_cnt_q;
        tx_sh_d = tx_sh_q;
        tx_rd_d = tx_rd_q;
        gen_d = bist_en ? gen_q : LFSR_SEED;
        if (tx_ready) begin
            tx_cnt_d = BIT_FIRST;
            tx_sh_d = tx_code; // [RQ1]
            if (bist_en || enc_en) begin
                tx_rd_d = enc_res[10];
            end
            if (bist_en) begin
                gen_d = lfsr(gen_q); // [RQ9]
            end
        end else if (bit_tick) begin
            tx_cnt_d = tx_cnt_q + 4'h1;
            tx_sh_d = {tx_sh_q[8:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_cnt_q <= BIT_LAST;
            tx_div_q <= 1'b0;
            tx_sh_q <= '0;
            tx_rd_q <= 1'b0;
            gen_q <= LFSR_SEED;
        end else begin
            tx_cnt_q <= tx_cnt_d;
            tx_div_q <= tx_div_d;
            tx_sh_q <= tx_sh_d;
            tx_rd_q <= tx_rd_d;
            gen_q <= gen_d;
        end
    end

    assign ser_out = tx_sh_q[9];

    // Receive side: deserializer, framer, decoder, self-test checker.
    logic [9:0] win_q, win_d;
    logic [3:0] rx_cnt_q, rx_cnt_d;
    logic pend_q, pend_d;
    logic [3:0] pend_ph_q, pend_ph_d;
    logic rx_rd_q, rx_rd_d;
    logic [7:0] chk_prev_q, chk_prev_d;
    logic chk_vld_q, chk_vld_d;
    logic bist_err_q, bist_err_d;
    logic rx_bit, det, aligned, mis, realign, char_done;
    logic [10:0] dec_res;
    logic [EB_W-1:0] eb_wdata;

    always_comb begin
        rx_bit = rx_in_sel ? rx_in1 : rx_in0; // [RQ4]
        win_d = rx_bit_vld ? {win_q[8:0], rx_bit} : win_q; // [RQ5]
        det = frame_en && (frame_full ? (win_d == K285_N || win_d == K285_P)
            : (win_d[9:3] == COMMA_N || win_d[9:3] == COMMA_P)); // [RQ11]
        aligned = rx_cnt_q == BIT_LAST;
        mis = rx_bit_vld && det && !aligned;
        // Multi-character mode wants the same misplaced boundary twice, so one bit error cannot slip framing.
        realign = mis && (!frame_multi || (pend_q && pend_ph_q == rx_cnt_q)); // [RQ11] [RQ13]
        char_done = rx_bit_vld && (aligned || realign); // [RQ13]
        dec_res = dec(win_d, rx_rd_q); // [RQ5] [RQ12]
        if (dec_en) begin
            eb_wdata = {dec_res[8], dec_res[9], 2'b00, dec_res[7:0]};
        end else begin
            eb_wdata = {2'b00, win_d}; // [RQ7]
        end
        rx_cnt_d = rx_cnt_q;
        if (rx_bit_vld) begin
            rx_cnt_d = char_done ? BIT_FIRST : rx_cnt_q + 4'h1;
        end
        pend_d = pend_q;
        pend_ph_d = pend_ph_q;
        if (rx_bit_vld && det) begin
            pend_d = mis && !realign;
            pend_ph_d = rx_cnt_q;
        end
        rx_rd_d = (char_done && dec_en) ? dec_res[10] : rx_rd_q;
        chk_prev_d = chk_prev_q;
        chk_vld_d = chk_vld_q && bist_en;
        bist_err_d = 1'b0;
        if (char_done && bist_en) begin
            chk_prev_d = dec_res[7:0];
            chk_vld_d = 1'b1;
            // The checker locks onto the incoming stream, so no seed has to be agreed with the far end.
            bist_err_d = chk_vld_q && (dec_res[7:0] != lfsr(chk_prev_q) || dec_res[9] || dec_res[8]); // [RQ9]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            win_q <= '0;
            rx_cnt_q <= BIT_FIRST;
            pend_q <= 1'b0;
            pend_ph_q <= BIT_FIRST;
            rx_rd_q <= 1'b0;
            chk_prev_q <= '0;
            chk_vld_q <= 1'b0;
            bist_err_q <= 1'b0;
        end else begin
            win_q <= win_d;
            rx_cnt_q <= rx_cnt_d;
            pend_q <= pend_d;
            pend_ph_q <= pend_ph_d;
            rx_rd_q <= rx_rd_d;
            chk_prev_q <= chk_prev_d;
            chk_vld_q <= chk_vld_d;
            bist_err_q <= bist_err_d;
        end
    end

    assign bist_err = bist_err_q;

    // Elasticity buffer and host output register. A full buffer drops the new character.
    logic [EB_W-1:0] eb_mem [EB_DEPTH];
    logic [EB_AW:0] wp_q, wp_d, rp_q, rp_d;
    logic [EB_W-1:0] out_q, out_d;
    logic vld_q, vld_d;
    logic eb_empty, eb_full, eb_wr, eb_rd;

    always_comb begin
        eb_empty = wp_q == rp_q;
        eb_full = (wp_q[EB_AW] != rp_q[EB_AW]) && (wp_q[EB_AW-1:0] == rp_q[EB_AW-1:0]);
        eb_wr = char_done && !eb_full; // [RQ6]
        eb_rd = !eb_empty && (rx_out_sel == SLC_OUT_RECOVERED || tx_ready); // [RQ8]
        wp_d = eb_wr ? wp_q + 1'b1 : wp_q;
        rp_d = eb_rd ? rp_q + 1'b1 : rp_q;
        out_d = eb_rd ? eb_mem[rp_q[EB_AW-1:0]] : out_q;
        vld_d = eb_rd;
    end

    always_ff @(posedge sys_clk) begin
        if (eb_wr) begin
            eb_mem[wp_q[EB_AW-1:0]] <= eb_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            out_q <= '0;
            vld_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            out_q <= out_d;
            vld_q <= vld_d;
        end
    end

    assign rx_data = out_q[9:0];
    assign rx_err = out_q[10]; // [RQ12]
    assign rx_k = out_q[11];
    assign rx_vld = vld_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_fast_char;
        tx_ready && rate_sel == SLC_RATE_X20 ##1 (rate_sel == SLC_RATE_X20) [*8] ##1 rate_sel == SLC_RATE_X20;
    endsequence
    chk_fast_char_period: assert property (s_fast_char |=> tx_ready) else $error("fast char period wrong"); // [RQ3]
    chk_slow_char_gap: assert property (tx_ready && rate_sel == SLC_RATE_X10 |=> (!tx_ready) [*8])
        else $error("slow char period too short"); // [RQ3]
    chk_ser_first_bit: assert property (tx_ready |=> ser_out == $past(tx_code[9]))
        else $error("first serial bit wrong"); // [RQ1]
    chk_enc_bypass_raw: assert property (tx_ready && !enc_en && !bist_en |=> tx_sh_q == $past(tx_data))
        else $error("bypass altered character"); // [RQ7]
    chk_bist_gen_step: assert property (bist_en && tx_ready ##1 bist_en |-> gen_q == lfsr($past(gen_q)))
        else $error("self-test generator did not step"); // [RQ9]
    chk_rx_input_select: assert property (rx_bit_vld |=> win_q[0] == $past(rx_in_sel ? rx_in1 : rx_in0))
        else $error("wrong serial input used"); // [RQ4]
    chk_single_realign: assert property (rx_bit_vld && det && !frame_multi |=> rx_cnt_q == BIT_FIRST)
        else $error("single framing did not realign"); // [RQ13]
    chk_multi_first_hold: assert property (frame_multi && mis && !pend_q |-> !char_done)
        else $error("multi framing moved on first pattern"); // [RQ11]
    sequence s_rx_direct;
        char_done && eb_empty && rx_out_sel == SLC_OUT_RECOVERED ##1 rx_out_sel == SLC_OUT_RECOVERED;
    endsequence
    chk_rx_err_passes: assert property (s_rx_direct |=> rx_vld && rx_err == $past(eb_wdata[10], 2))
        else $error("error flag not delivered"); // [RQ12]
    chk_ebuf_local_out: assert property (rx_out_sel == SLC_OUT_LOCAL && rx_vld |-> $past(tx_ready))
        else $error("local output off reference timing"); // [RQ8]
    chk_ebuf_write: assert property (eb_wr |=> !eb_empty) else $error("buffer write lost"); // [RQ6]
endmodule
`default_nettype wire

// File: common/slc_pkg.sv
// Shared constants and code tables for the serial link channel core.
`default_nettype none
package slc_pkg;
    localparam int CHAR_W = 10;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BIT_LAST = 4'h9;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    // Comma and K28.5 patterns, first transmitted bit in the MSB.
    localparam logic [6:0] COMMA_N = 7'h1f;
    localparam logic [6:0] COMMA_P = 7'h60;
    localparam logic [9:0] K285_N = 10'h0fa;
    localparam logic [9:0] K285_P = 10'h305;
    localparam logic [5:0] K28_6B_N = 6'h0f;
    localparam logic [5:0] K28_6B_P = 6'h30;
    localparam logic [4:0] K28_X = 5'h1c;
    localparam logic [5:0] D7_6B_N = 6'h38;
    localparam logic [3:0] ALT7_N = 4'h7;
    localparam logic [3:0] ALT7_P = 4'h8;
    localparam logic [3:0] DX3_N = 4'hc;
    localparam logic [3:0] DX3_P = 4'h3;
    localparam logic [2:0] Y_ALT = 3'h7;
    localparam logic [2:0] Y_THREE = 3'h3;
    localparam int ONES6_BAL = 3;
    localparam int ONES6_HI = 4;
    localparam int ONES6_LO = 2;
    localparam int ONES4_BAL = 2;
    localparam int ONES4_HI = 3;
    localparam int ONES4_LO = 1;
    // 5b/6b and 3b/4b codes for negative running disparity.
    localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
        6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
    // Self-test sequence generator.
    localparam logic [7:0] LFSR_POLY = 8'hb8;
    localparam logic [7:0] LFSR_SEED = 8'h01;
    // Elasticity buffer geometry.
    localparam int EB_AW = 3;
    localparam int EB_DEPTH = 8;
    localparam int EB_W = 12;
    typedef enum logic {SLC_RATE_X10, SLC_RATE_X20} slc_rate_t;
    typedef enum logic {SLC_OUT_RECOVERED, SLC_OUT_LOCAL} slc_outclk_t;
endpackage
`default_nettype wire

// File: test/slc_host_model.sv
// Host-side model: feeds transmit characters and collects received ones.
`timescale 1ns/1ns
`default_nettype none
module slc_host_model (
    input wire logic sys_clk,
    input wire logic enc_en,
    input wire logic tx_ready,
    output logic [9:0] tx_data,
    output logic tx_k,
    input wire logic [9:0] rx_data,
    input wire logic rx_k,
    input wire logic rx_err,
    input wire logic rx_vld
);
    import slc_pkg::*;
    logic [10:0] txq [$];
    logic [11:0] rxq [$];
    logic idle_p = 1'b0;
    logic from_q = 1'b0;
    // A character leaves the queue only once the edge that took it has passed.
    always @(posedge sys_clk) begin
        if (rx_vld === 1'b1) rxq.push_back({rx_err, rx_k, rx_data});
        if (tx_ready === 1'b1 && from_q) void'(txq.pop_front());
        if (tx_ready === 1'b1 && !from_q) idle_p = !idle_p;
        #1;
        from_q = txq.size() > 0;
        // Idle commas keep the far framer aligned; raw idle alternates so disparity stays legal.
        if (from_q) {tx_k, tx_data} = txq[0];
        else if (enc_en) {tx_k, tx_data} = {1'b1, 10'h0bc};
        else {tx_k, tx_data} = {1'b0, idle_p ? K285_P : K285_N};
    end
endmodule
`default_nettype wire

// File: test/tb_slc_channel.sv
// Self-checking bench for one channel, serial output looped back to the receiver.
`timescale 1ns/1ns
`default_nettype none
module tb_slc_channel;
    import slc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic enc_en = 1'b1;
    logic dec_en = 1'b1;
    slc_rate_t rate_sel = SLC_RATE_X20;
    slc_outclk_t rx_out_sel = SLC_OUT_RECOVERED;
    logic rx_in_sel = 1'b0;
    logic rx_bit_vld = 1'b0;
    logic frame_en = 1'b1;
    logic frame_full = 1'b0;
    logic frame_multi = 1'b0;
    logic bist_en = 1'b0;
    logic corrupt = 1'b0;
    logic slip = 1'b0;
    logic ph = 1'b0;
    logic txr_q = 1'b0;
    logic [9:0] tx_data;
    logic [9:0] rx_data;
    logic tx_k, tx_ready, ser_out, rx_k, rx_err, rx_vld, bist_err;
    wire rx_in0;
    wire rx_in1;
    int errors = 0;
    int cmp_count = 0;
    // The unselected input carries inverted data, so a wrong selection breaks the stream.
    assign rx_in0 = rx_in_sel ? ~ser_out : ser_out ^ corrupt;
    assign rx_in1 = rx_in_sel ? ser_out ^ corrupt : ~ser_out;
    slc_channel slc_channel_inst (.sys_clk, .rst, .enc_en, .dec_en, .rate_sel, .tx_data, .tx_k, .tx_ready,
        .ser_out, .rx_in_sel, .rx_in0, .rx_in1, .rx_bit_vld, .frame_en, .frame_full, .frame_multi,
        .rx_out_sel, .bist_en, .rx_data, .rx_k, .rx_err, .rx_vld, .bist_err);
    slc_host_model slc_host_model_inst (.sys_clk, .enc_en, .tx_ready, .tx_data, .tx_k, .rx_data, .rx_k,
        .rx_err, .rx_vld);
    initial forever #4 sys_clk = ~sys_clk;
    // One recovered bit per serial bit time; at SLC_RATE_X20 a slip drops exactly one bit.
    always @(posedge sys_clk) begin
        #1;
        ph = ~ph;
        rx_bit_vld = (rate_sel == SLC_RATE_X20 || ph) && !slip;
        slip = 1'b0;
    end
    // Sampled mid-cycle so the registered output is settled and the previous cycle's tx_ready is held.
    always @(negedge sys_clk) begin
        if (!rst && rx_vld === 1'b1 && rx_out_sel == SLC_OUT_LOCAL)
            chk1("rx_vld after tx_ready", 1'b1, txr_q);
        txr_q = tx_ready;
    end
    task automatic conclude();
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic hang(input string what);
        errors++;
        $display("[FAIL] %s expected done seen timeout", what);
        conclude();
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Entry is {err, k, data}; an expected error entry compares only the error flag.
    task automatic chk12(input string what, input logic [11:0] exp, input logic [11:0] got);
        logic [11:0] msk;
        msk = exp[11] ? 12'h800 : 12'hfff;
        cmp_count++;
        if ((got & msk) !== (exp & msk)) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic start(input logic enc, input logic dec, input slc_rate_t rate, input logic sel,
                         input slc_outclk_t osel, input logic full, input logic multi);
        @(posedge sys_clk);
        #1;
        rst = 1'b1;
        enc_en = enc;
        dec_en = dec;
        rate_sel = rate;
        rx_in_sel = sel;
        rx_out_sel = osel;
        frame_full = full;
        frame_multi = multi;
        slc_host_model_inst.txq.delete();
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        // Idle commas run long enough for the framer to settle in either mode.
        repeat (160) @(posedge sys_clk);
        #1;
        slc_host_model_inst.rxq.delete();
    endtask
    task automatic run_stream(input logic [10:0] tx [$], input logic [11:0] ex [$]);
        int a;
        int n;
        a = -1;
        foreach (tx[i]) slc_host_model_inst.txq.push_back(tx[i]);
        for (n = 0; n < 4000; n++) begin
            @(negedge sys_clk);
            foreach (slc_host_model_inst.rxq[i]) if (a < 0 && slc_host_model_inst.rxq[i] === ex[0]) a = i;
            if (a >= 0 && slc_host_model_inst.rxq.size() >= a + ex.size()) break;
        end
        if (n == 4000) hang("rx stream");
        foreach (ex[i]) chk12("rx char", ex[i], slc_host_model_inst.rxq[a + i]);
    endtask
    task automatic send_enc();
        logic [10:0] tx [$];
        logic [11:0] ex [$];
        tx = '{11'h000, 11'h0ff, 11'h05a, 11'h4bc, 11'h0a5, 11'h41c, 11'h47c};
        foreach (tx[i]) ex.push_back({1'b0, tx[i][10], 2'b00, tx[i][7:0]});
        run_stream(tx, ex);
    endtask
    task automatic wire_check(input logic [9:0] code);
        int n;
        int reps;
        reps = rate_sel == SLC_RATE_X20 ? 1 : 2;
        slc_host_model_inst.txq.push_back({1'b0, code});
        for (n = 0; n < 100 && !(tx_ready === 1'b1 && tx_data === code); n++) @(negedge sys_clk);
        if (n == 100) hang("tx_ready");
        for (int i = 9; i >= 0; i--) begin
            for (int r = 0; r < reps; r++) begin
                @(negedge sys_clk);
                chk1("ser_out bit", code[i], ser_out);
                chk1("tx_ready spacing", i == 0 && r == reps - 1, tx_ready);
            end
        end
    endtask
    task automatic sc_encoded_frames();
        for (int f = 0; f < 4; f++) begin
            start(1'b1, 1'b1, SLC_RATE_X20, 1'b0, SLC_OUT_RECOVERED, f[0], f[1]);
            send_enc();
        end
    endtask
    task automatic sc_slow_alt_input();
        start(1'b1, 1'b1, SLC_RATE_X10, 1'b1, SLC_OUT_LOCAL, 1'b0, 1'b0);
        send_enc();
    endtask
    task automatic sc_raw_wire();
        start(1'b0, 1'b0, SLC_RATE_X20, 1'b0, SLC_OUT_RECOVERED, 1'b0, 1'b0);
        wire_check(10'h2cc);
        run_stream('{11'h2aa, 11'h155, 11'h333}, '{12'h2aa, 12'h155, 12'h333});
        start(1'b0, 1'b0, SLC_RATE_X10, 1'b0, SLC_OUT_RECOVERED, 1'b0, 1'b0);
        wire_check(10'h333);
    endtask
    task automatic sc_bad_code();
        start(1'b0, 1'b1, SLC_RATE_X20, 1'b0, SLC_OUT_RECOVERED, 1'b0, 1'b0);
        run_stream('{11'h2aa, 11'h000, 11'h2aa}, '{12'h0b5, 12'h800, 12'h0b5});
    endtask
    task automatic sc_bit_slip();
        start(1'b1, 1'b1, SLC_RATE_X20, 1'b0, SLC_OUT_RECOVERED, 1'b0, 1'b0);
        @(negedge sys_clk);
        slip = 1'b1;
        run_stream('{11'h4bc, 11'h03c, 11'h0c3, 11'h081}, '{12'h03c, 12'h0c3, 12'h081});
    endtask
    // With framing off, a slipped boundary must stay slipped even though commas keep arriving.
    task automatic sc_frame_off();
        int n;
        int hits;
        start(1'b1, 1'b1, SLC_RATE_X20, 1'b0, SLC_OUT_RECOVERED, 1'b0, 1'b0);
        frame_en = 1'b0;
        @(negedge sys_clk);
        slip = 1'b1;
        repeat (2) begin
            slc_host_model_inst.txq.push_back(11'h4bc);
            slc_host_model_inst.txq.push_back(11'h03c);
        end
        hits = 0;
        for (n = 0; n < 200; n++) begin
            @(negedge sys_clk);
            hits += int'(rx_vld === 1'b1 && {rx_err, rx_k, rx_data} === 12'h03c);
        end
        chk1("frame off keeps boundary", 1'b0, hits != 0);
        @(posedge sys_clk);
        #1 frame_en = 1'b1;
    endtask
    task automatic sc_self_test();
        int hits;
        start(1'b1, 1'b1, SLC_RATE_X20, 1'b0, SLC_OUT_RECOVERED, 1'b0, 1'b0);
        bist_en = 1'b1;
        repeat (60) @(posedge sys_clk);
        hits = 0;
        repeat (400) begin
            @(negedge sys_clk);
            hits += int'(bist_err === 1'b1);
        end
        chk1("bist clean link", 1'b0, hits != 0);
        @(posedge sys_clk);
        #1 corrupt = 1'b1;
        @(posedge sys_clk);
        #1 corrupt = 1'b0;
        hits = 0;
        repeat (80) begin
            @(negedge sys_clk);
            hits += int'(bist_err === 1'b1);
        end
        chk1("bist fault seen", 1'b1, hits != 0);
        @(posedge sys_clk);
        #1 bist_en = 1'b0;
    endtask
    initial begin
        sc_encoded_frames();
        sc_slow_alt_input();
        sc_raw_wire();
        sc_bad_code();
        sc_bit_slip();
        sc_frame_off();
        sc_self_test();
        conclude();
    end
endmodule
`default_nettype wire
